// ===== pcd_pkg.sv
/*
  Constants for the per-port PHY cable-diagnostic and link control bank:
  register offsets, bit positions, reset values, outcome codes and timing.
  Assumes a 100 MHz system clock shared by every user of the package.
*/
package pcd_pkg;
  localparam int NPORT = 2;
  localparam int CNT_W = 9;

  // Register offsets, one entry per port
  localparam logic [7:0] SPECIAL_OFS [NPORT] = '{8'h1A, 8'h2A};
  localparam logic [7:0] RESULT_OFS  [NPORT] = '{8'h1B, 8'h2B};
  localparam logic [7:0] CTRL12_OFS  [NPORT] = '{8'h1C, 8'h2C};

  // Special control/status fields
  localparam int SP_NEAR_SHORT = 7;
  localparam int SP_OUT_MSB    = 6;
  localparam int SP_OUT_LSB    = 5;
  localparam int SP_START      = 4;
  localparam int SP_FORCE_LINK = 3;
  localparam int SP_RSVD       = 2;
  localparam int SP_LOOPBACK   = 1;
  localparam int SP_CNT_MSB    = 0;

  // Control register twelve fields
  localparam int C12_AN_EN  = 7;
  localparam int C12_SPEED  = 6;
  localparam int C12_DUPLEX = 5;
  localparam logic [7:0] C12_RESET = 8'hFF;
  localparam logic [7:0] RD_IDLE   = 8'h00;

  // Cable test outcome codes
  localparam logic [1:0] OUT_NORMAL = 2'h0;
  localparam logic [1:0] OUT_OPEN   = 2'h1;
  localparam logic [1:0] OUT_SHORT  = 2'h2;
  localparam logic [1:0] OUT_FAIL   = 2'h3;

  // Timing and distance scaling
  localparam int CLK_PERIOD_NS   = 10;
  localparam int UNIT_MM         = 400;
  localparam int CABLE_MM_PER_NS = 200;
  localparam int NEAR_SHORT_MM   = 10000;
  localparam int LISTEN_NS       = 2050;
  localparam int LISTEN_CYCLES   = LISTEN_NS / CLK_PERIOD_NS;
  localparam int NEAR_UNITS      = NEAR_SHORT_MM / UNIT_MM;
  localparam int CNT_MAX         = (1 << CNT_W) - 1;
  localparam logic [1:0] STRAP_SETTLE = 2'h2;
endpackage

// ===== pcd_diag_if.sv
/*
  Interface between the register bank and one cable test engine.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/100ps
interface pcd_diag_if;
  logic                    start;
  logic                    busy;
  logic                    done;
  logic [1:0]              outcome;
  logic [pcd_pkg::CNT_W-1:0] count;
  logic                    near_short;

  modport ctrl (output start, input busy, done, outcome, count, near_short);
  modport eng  (input start, output busy, done, outcome, count, near_short);
endinterface

// ===== pcd_cable_test.sv
/*
  Cable test engine for one port: launches a reflectometry pulse, times
  the echo and reports outcome and distance in 0.4 m units.
  Assumes echo inputs are already synchronised to clk.
*/
`timescale 1ns/100ps
module pcd_cable_test #(
  parameter int LISTEN = pcd_pkg::LISTEN_CYCLES
) (
  // Clock and reset
  input  wire logic  clk,
  input  wire logic  rst_n,
  // Analog front end
  input  wire logic  echo_seen,
  input  wire logic  echo_open,
  input  wire logic  echo_short,
  output logic       tdr_pulse,
  // Register bank side
  pcd_diag_if.eng    dif
);
  import pcd_pkg::*;

  typedef enum logic [1:0] {PCD_IDLE, PCD_LAUNCH, PCD_LISTEN} pcd_state_t;
  localparam int DONE_MAX = LISTEN + 3;

  pcd_state_t        state_reg;
  logic [15:0]       elapsed_reg;
  logic [CNT_W-1:0]  count_reg;
  logic [1:0]        outcome_reg;
  logic              near_reg;
  logic              done_reg;
  logic              pulse_reg;
  logic [31:0]       units_next;
  logic [CNT_W-1:0]  sat_next;

  // Round trip at cable velocity, halved, in distance units
  always_comb
  begin
    units_next = (32'(elapsed_reg) * 32'(CLK_PERIOD_NS * CABLE_MM_PER_NS))
                 / 32'(2 * UNIT_MM);
    sat_next   = (units_next > 32'(CNT_MAX)) ? CNT_W'(CNT_MAX)
                                             : units_next[CNT_W-1:0];
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state_reg <= PCD_IDLE;
    else
      case (state_reg)
        PCD_IDLE:   if (dif.start) state_reg <= PCD_LAUNCH;
        PCD_LAUNCH: state_reg <= PCD_LISTEN;
        PCD_LISTEN:
          if (echo_seen || elapsed_reg == 16'(LISTEN - 1))
            state_reg <= PCD_IDLE;
        default:    state_reg <= PCD_IDLE;
      endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      elapsed_reg <= 16'h0000;
    else if (state_reg == PCD_LISTEN)
      elapsed_reg <= elapsed_reg + 16'h0001;
    else
      elapsed_reg <= 16'h0000;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pulse_reg <= 1'b0;
    else
      pulse_reg <= (state_reg == PCD_IDLE) && dif.start;
  end

  // Result capture; no echo inside the window means a good cable
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      outcome_reg <= OUT_NORMAL;
      count_reg   <= '0;
      near_reg    <= 1'b0;
      done_reg    <= 1'b0;
    end
    else
    begin
      done_reg <= 1'b0;
      if (state_reg == PCD_LISTEN && echo_seen)
      begin
        done_reg  <= 1'b1;
        count_reg <= sat_next;
        if (echo_open && !echo_short)
          outcome_reg <= OUT_OPEN;
        else if (echo_short && !echo_open)
          outcome_reg <= OUT_SHORT;
        else
          outcome_reg <= OUT_FAIL;
        near_reg <= echo_short && !echo_open
                    && (32'(sat_next) < 32'(NEAR_UNITS));
      end
      else if (state_reg == PCD_LISTEN && elapsed_reg == 16'(LISTEN - 1))
      begin
        done_reg    <= 1'b1;
        count_reg   <= '0;
        outcome_reg <= OUT_NORMAL;
        near_reg    <= 1'b0;
      end
    end
  end

  assign tdr_pulse      = pulse_reg;
  assign dif.busy       = (state_reg != PCD_IDLE);
  assign dif.done       = done_reg;
  assign dif.outcome    = outcome_reg;
  assign dif.count      = count_reg;
  assign dif.near_short = near_reg;

  test_ends_a: assert property (@(posedge clk) disable iff (!rst_n)
    (dif.start && !dif.busy) |-> ##[1:DONE_MAX] dif.done)
    else $error("cable test did not finish in time");

  scale_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == PCD_LISTEN && echo_seen && elapsed_reg < 16'h00C8)
    |=> (32'(dif.count) == ($past(32'(elapsed_reg)) * 32'h5) / 32'h2))
    else $error("fault distance scaling wrong");

  outcome_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == PCD_LISTEN && echo_seen && echo_open && !echo_short)
    |=> dif.done && dif.outcome == OUT_OPEN)
    else $error("open cable not reported");
endmodule

// ===== pcd_top.sv
/*
  Register bank for the two copper PHY ports: cable test control and
  result, forced link, remote loopback, auto-negotiation and forced
  speed/duplex, with strap defaults for auto-negotiation and speed. Assumes a single-cycle register
  port from the management logic and asynchronous PHY status pins.
*/
`timescale 1ns/100ps
module pcd_top (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  // Register port
  input  wire logic [7:0]                 reg_addr,
  input  wire logic                       reg_wr_en,
  input  wire logic                       reg_rd_en,
  input  wire logic [7:0]                 reg_wdata,
  output logic      [7:0]                 reg_rdata,
  output logic                            reg_rd_valid,
  // Strap pins
  input  wire logic                       port1_led0_strap,
  input  wire logic                       port1_led1_strap,
  input  wire logic                       port2_autoneg_strap,
  input  wire logic                       port2_speed_strap,
  // PHY status pins, bit 0 is port 1
  input  wire logic [pcd_pkg::NPORT-1:0]  phy_link_ok,
  input  wire logic [pcd_pkg::NPORT-1:0]  an_failed,
  input  wire logic [pcd_pkg::NPORT-1:0]  an_speed_100,
  input  wire logic [pcd_pkg::NPORT-1:0]  an_full_duplex,
  input  wire logic [pcd_pkg::NPORT-1:0]  echo_seen,
  input  wire logic [pcd_pkg::NPORT-1:0]  echo_open,
  input  wire logic [pcd_pkg::NPORT-1:0]  echo_short,
  // PHY controls
  output logic      [pcd_pkg::NPORT-1:0]  link_pass,
  output logic      [pcd_pkg::NPORT-1:0]  remote_loopback,
  output logic      [pcd_pkg::NPORT-1:0]  an_enable,
  output logic      [pcd_pkg::NPORT-1:0]  speed_100,
  output logic      [pcd_pkg::NPORT-1:0]  full_duplex,
  output logic      [pcd_pkg::NPORT-1:0]  tdr_pulse
);
  import pcd_pkg::*;

  localparam int SYNC_W = 4 + 7 * NPORT;

  logic [SYNC_W-1:0]  sync1_reg;
  logic [SYNC_W-1:0]  sync2_reg;
  logic [NPORT-1:0]   link_s;
  logic [NPORT-1:0]   anfail_s;
  logic [NPORT-1:0]   anspd_s;
  logic [NPORT-1:0]   anfull_s;
  logic [NPORT-1:0]   echo_seen_s;
  logic [NPORT-1:0]   echo_open_s;
  logic [NPORT-1:0]   echo_short_s;
  logic [NPORT-1:0]   strap_an_s;
  logic [NPORT-1:0]   strap_spd_s;
  logic [1:0]         strap_cnt_reg;

  logic [NPORT-1:0]   start_reg;
  logic [NPORT-1:0]   force_link_reg;
  logic [NPORT-1:0]   loopback_reg;
  logic [7:0]         ctrl12_reg [NPORT];

  logic [NPORT-1:0]   sel_special;
  logic [NPORT-1:0]   sel_result;
  logic [NPORT-1:0]   sel_ctrl12;
  logic [NPORT-1:0]   launch;
  logic [NPORT-1:0]   busy_w;
  logic [NPORT-1:0]   done_w;
  logic [NPORT-1:0]   near_w;
  logic [1:0]         outcome_w [NPORT];
  logic [CNT_W-1:0]   count_w   [NPORT];
  logic [7:0]         rd_next;

  // Two-stage synchroniser for every pin input
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end
    else
    begin
      sync1_reg <= {port2_speed_strap, port1_led1_strap,
                    port2_autoneg_strap, port1_led0_strap,
                    phy_link_ok, an_failed, an_speed_100, an_full_duplex,
                    echo_seen, echo_open, echo_short};
      sync2_reg <= sync1_reg;
    end
  end

  assign {strap_spd_s, strap_an_s, link_s, anfail_s, anspd_s, anfull_s,
          echo_seen_s, echo_open_s, echo_short_s} = sync2_reg;

  // Waits for the straps to clear the synchroniser after reset
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      strap_cnt_reg <= 2'h0;
    else if (strap_cnt_reg != STRAP_SETTLE + 2'h1)
      strap_cnt_reg <= strap_cnt_reg + 2'h1;
  end

  // Address decode
  always_comb
  begin
    for (int p = 0; p < NPORT; p++)
    begin
      sel_special[p] = (reg_addr == SPECIAL_OFS[p]);
      sel_result[p]  = (reg_addr == RESULT_OFS[p]);
      sel_ctrl12[p]  = (reg_addr == CTRL12_OFS[p]);
      launch[p]      = reg_wr_en && sel_special[p] && reg_wdata[SP_START]
                       && (!start_reg[p] || done_w[p]);
    end
  end

  // Cable test start bit: set by software, cleared by the engine
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      start_reg <= '0;
    else
      for (int p = 0; p < NPORT; p++)
        if (launch[p])
          start_reg[p] <= 1'b1;
        else if (done_w[p])
          start_reg[p] <= 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      force_link_reg <= '0;
      loopback_reg   <= '0;
    end
    else
      for (int p = 0; p < NPORT; p++)
        if (reg_wr_en && sel_special[p])
        begin
          force_link_reg[p] <= reg_wdata[SP_FORCE_LINK];
          loopback_reg[p]   <= reg_wdata[SP_LOOPBACK];
        end
  end

  // Control twelve; strap values land once the synchroniser is settled
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      for (int p = 0; p < NPORT; p++)
        ctrl12_reg[p] <= C12_RESET;
    else
      for (int p = 0; p < NPORT; p++)
        if (strap_cnt_reg == STRAP_SETTLE)
        begin
          ctrl12_reg[p][C12_AN_EN] <= strap_an_s[p];
          ctrl12_reg[p][C12_SPEED] <= strap_spd_s[p];
        end
        else if (reg_wr_en && sel_ctrl12[p])
          ctrl12_reg[p] <= reg_wdata;
  end

  // Read data; unmapped addresses read zero
  always_comb
  begin
    rd_next = RD_IDLE;
    for (int p = 0; p < NPORT; p++)
    begin
      if (sel_special[p])
      begin
        rd_next[SP_NEAR_SHORT]         = near_w[p];
        rd_next[SP_OUT_MSB:SP_OUT_LSB] = outcome_w[p];
        rd_next[SP_START]              = start_reg[p];
        rd_next[SP_FORCE_LINK]         = force_link_reg[p];
        rd_next[SP_RSVD]               = 1'b0;
        rd_next[SP_LOOPBACK]           = loopback_reg[p];
        rd_next[SP_CNT_MSB]            = count_w[p][CNT_W-1];
      end
      if (sel_result[p])
        rd_next = count_w[p][7:0];
      if (sel_ctrl12[p])
        rd_next = ctrl12_reg[p];
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata    <= RD_IDLE;
      reg_rd_valid <= 1'b0;
    end
    else
    begin
      reg_rd_valid <= reg_rd_en;
      if (reg_rd_en)
        reg_rdata <= rd_next;
    end
  end

  // Per-port PHY mode controls, registered
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      link_pass       <= '0;
      remote_loopback <= '0;
      an_enable       <= '0;
      speed_100       <= '0;
      full_duplex     <= '0;
    end
    else
      for (int p = 0; p < NPORT; p++)
      begin
        link_pass[p]       <= force_link_reg[p] || link_s[p];
        remote_loopback[p] <= loopback_reg[p];
        an_enable[p]       <= ctrl12_reg[p][C12_AN_EN];
        speed_100[p]       <= ctrl12_reg[p][C12_AN_EN] ? anspd_s[p]
                              : ctrl12_reg[p][C12_SPEED];
        full_duplex[p]     <= (ctrl12_reg[p][C12_AN_EN] && !anfail_s[p])
                              ? anfull_s[p]
                              : ctrl12_reg[p][C12_DUPLEX];
      end
  end

  for (genvar p = 0; p < NPORT; p++)
  begin : g_port
    pcd_diag_if dif ();

    assign dif.start    = launch[p];
    assign busy_w[p]    = dif.busy;
    assign done_w[p]    = dif.done;
    assign near_w[p]    = dif.near_short;
    assign outcome_w[p] = dif.outcome;
    assign count_w[p]   = dif.count;

    pcd_cable_test u_test (
      .clk        (clk),
      .rst_n      (rst_n),
      .echo_seen  (echo_seen_s[p]),
      .echo_open  (echo_open_s[p]),
      .echo_short (echo_short_s[p]),
      .tdr_pulse  (tdr_pulse[p]),
      .dif        (dif)
    );

    start_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
      done_w[p] && !launch[p] |=> !start_reg[p])
      else $error("start bit not cleared after test");

    results_valid_a: assert property (@(posedge clk) disable iff (!rst_n)
      !start_reg[p] |-> !busy_w[p])
      else $error("start bit low while test runs");

    force_link_a: assert property (@(posedge clk) disable iff (!rst_n)
      force_link_reg[p] |=> link_pass[p])
      else $error("forced link not reported");

    normal_link_a: assert property (@(posedge clk) disable iff (!rst_n)
      !force_link_reg[p] |=> link_pass[p] == $past(link_s[p]))
      else $error("link pass does not follow link detection");

    loopback_out_a: assert property (@(posedge clk) disable iff (!rst_n)
      reg_wr_en && sel_special[p]
      |=> ##1 remote_loopback[p] == $past(reg_wdata[SP_LOOPBACK], 2))
      else $error("loopback control not applied");

    count_read_a: assert property (@(posedge clk) disable iff (!rst_n)
      reg_rd_en && sel_result[p] |=> reg_rdata == $past(count_w[p][7:0]))
      else $error("fault count low byte misread");

    forced_speed_a: assert property (@(posedge clk) disable iff (!rst_n)
      !ctrl12_reg[p][C12_AN_EN]
      |=> speed_100[p] == $past(ctrl12_reg[p][C12_SPEED]))
      else $error("forced speed not applied");

    forced_duplex_a: assert property (@(posedge clk) disable iff (!rst_n)
      (!ctrl12_reg[p][C12_AN_EN] || anfail_s[p])
      |=> full_duplex[p] == $past(ctrl12_reg[p][C12_DUPLEX]))
      else $error("forced duplex not applied");

    strap_load_a: assert property (@(posedge clk) disable iff (!rst_n)
      strap_cnt_reg == STRAP_SETTLE
      |=> ctrl12_reg[p][C12_AN_EN] == $past(strap_an_s[p])
          && ctrl12_reg[p][C12_SPEED] == $past(strap_spd_s[p]))
      else $error("strap default not loaded");

    reserved_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
      reg_rd_en && sel_special[p] |=> !reg_rdata[SP_RSVD])
      else $error("reserved bit reads nonzero");
  end
endmodule

// ===== pcd_echo_model.sv
/*
  Behavioural cable and echo front end for both ports: after each launch
  pulse in a fault mode it answers with an echo of the commanded kind after a set delay.
  Assumes the bench sets kind and delay before it starts a test.
*/
`timescale 1ns/100ps
module pcd_echo_model (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  // Bench control
  input  wire logic [1:0]                mode,
  input  wire logic [8:0]                delay,
  // Front end
  input  wire logic [pcd_pkg::NPORT-1:0] tdr_pulse,
  output logic      [pcd_pkg::NPORT-1:0] echo_seen,
  output logic      [pcd_pkg::NPORT-1:0] echo_open,
  output logic      [pcd_pkg::NPORT-1:0] echo_short
);
  import pcd_pkg::*;
  logic [8:0] wait_reg [NPORT];
  logic [2:0] hold_reg [NPORT];
  logic       toggle_reg;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      toggle_reg <= 1'b0;
      for (int p = 0; p < NPORT; p++)
      begin
        wait_reg[p] <= 9'h000;
        hold_reg[p] <= 3'h0;
      end
    end
    else
    begin
      toggle_reg <= ~toggle_reg;
      for (int p = 0; p < NPORT; p++)
      begin
        if (tdr_pulse[p] && mode != OUT_NORMAL)
          wait_reg[p] <= delay;
        else if (wait_reg[p] != 9'h000)
          wait_reg[p] <= wait_reg[p] - 9'h001;
        // Echo held four cycles, longer than the front end needs
        if (wait_reg[p] == 9'h001)
          hold_reg[p] <= 3'h4;
        else if (hold_reg[p] != 3'h0)
          hold_reg[p] <= hold_reg[p] - 3'h1;
      end
    end
  end

  // Polarity lines carry a changing pattern outside an echo
  always_comb
  begin
    for (int p = 0; p < NPORT; p++)
    begin
      echo_seen[p]  = hold_reg[p] != 3'h0;
      echo_open[p]  = echo_seen[p] ?
                      (mode == OUT_OPEN || mode == OUT_FAIL) : toggle_reg;
      echo_short[p] = echo_seen[p] ?
                      (mode == OUT_SHORT || mode == OUT_FAIL) : ~toggle_reg;
    end
  end
endmodule

// ===== tb_pcd_top.sv
/*
  Self-checking bench for the PHY diagnostic and link control bank.
  Assumes the single-cycle register port and the default listen window.
*/
`timescale 1ns/100ps
module tb_pcd_top;
  import pcd_pkg::*;
  logic       clk;
  logic       rst_n;
  logic       reg_wr_en;
  logic       reg_rd_en;
  logic       reg_rd_valid;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic [7:0] rd;
  logic       p1_s0;
  logic       p1_s1;
  logic       p2_an;
  logic       p2_sp;
  logic [1:0] link_ok;
  logic [1:0] an_fail;
  logic [1:0] an_spd;
  logic [1:0] an_fd;
  logic [1:0] e_seen;
  logic [1:0] e_open;
  logic [1:0] e_short;
  logic [1:0] link_pass;
  logic [1:0] loopb;
  logic [1:0] an_en;
  logic [1:0] spd;
  logic [1:0] fd;
  logic [1:0] tdr;
  logic [1:0] mode;
  logic [8:0] delay;
  logic [8:0] cnt;
  int         n_errors = 0;
  int         n_tests = 0;
  int         cyc = 0;
  int         p;
  int         k;
  int         lo;
  localparam logic [1:0] MDS [5] = '{OUT_OPEN, OUT_SHORT, OUT_SHORT,
                                     OUT_FAIL, OUT_NORMAL};
  localparam int         DLS [5] = '{40, 120, 2, 60, 1};
  localparam int         PRT [5] = '{0, 1, 0, 1, 0};

  pcd_top pcd_top_inst (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
    .port1_led0_strap(p1_s0), .port1_led1_strap(p1_s1),
    .port2_autoneg_strap(p2_an), .port2_speed_strap(p2_sp),
    .phy_link_ok(link_ok), .an_failed(an_fail), .an_speed_100(an_spd),
    .an_full_duplex(an_fd), .echo_seen(e_seen), .echo_open(e_open),
    .echo_short(e_short), .link_pass(link_pass), .remote_loopback(loopb),
    .an_enable(an_en), .speed_100(spd), .full_duplex(fd), .tdr_pulse(tdr));

  pcd_echo_model pcd_echo_model_inst (.clk(clk), .rst_n(rst_n),
    .mode(mode), .delay(delay), .tdr_pulse(tdr), .echo_seen(e_seen),
    .echo_open(e_open), .echo_short(e_short));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 12000)
    begin
      n_errors++;
      conclude();
    end
  end

  task automatic conclude();
    if (n_errors == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [8:0] e,
                     input logic [8:0] g);
    n_tests++;
    if (g !== e)
    begin
      n_errors++;
      $display("BAD %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(negedge clk);
    reg_wr_en = 1'b0;
  endtask

  task automatic rdr(input logic [7:0] a);
    @(negedge clk);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(negedge clk);
    reg_rd_en = 1'b0;
    chk("rd_valid", 9'h001, {8'h00, reg_rd_valid});
    rd = reg_rdata;
  endtask

  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [7:0] e);
    rdr(a);
    chk(nm, {1'b0, e}, {1'b0, rd});
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  initial
  begin
    {reg_wr_en, reg_rd_en, reg_addr, reg_wdata} = '0;
    {p1_s0, p1_s1, p2_an, p2_sp} = 4'h6;
    {link_ok, an_fail, an_spd, an_fd} = '0;
    mode = OUT_NORMAL;
    delay = 9'h001;
    rst_n = 1'b0;
    idle(16);
    rst_n = 1'b1;
    idle(6);
    rdc("p1_ctrl12", CTRL12_OFS[0], 8'h7F);
    rdc("p2_ctrl12", CTRL12_OFS[1], 8'hBF);
    chk("an_enable", 9'h002, {7'h00, an_en});
    chk("speed_100", 9'h001, {7'h00, spd});
    chk("full_duplex", 9'h001, {7'h00, fd});
    rdc("special", SPECIAL_OFS[0], 8'h00);
    rdc("result", RESULT_OFS[1], 8'h00);
    wr(8'h1D, 8'h55);
    rdc("unmapped", 8'h1D, RD_IDLE);
    wr(SPECIAL_OFS[0], 8'hEB);
    rdc("special_ro", SPECIAL_OFS[0], 8'h0A);
    chk("link_pass", 9'h001, {7'h00, link_pass});
    chk("loopback", 9'h001, {7'h00, loopb});
    wr(SPECIAL_OFS[0], 8'h00);
    idle(1);
    chk("link_pass", 9'h000, {7'h00, link_pass});
    chk("loopback", 9'h000, {7'h00, loopb});
    link_ok = 2'b10;
    idle(4);
    chk("link_pass", 9'h002, {7'h00, link_pass});
    for (p = 0; p < NPORT; p++)
    begin
      an_spd = 2'b00;
      an_fd = 2'b00;
      wr(CTRL12_OFS[p], 8'h1F);
      idle(1);
      chk("an_off", 9'h000, {8'h00, an_en[p]});
      chk("spd_10", 9'h000, {8'h00, spd[p]});
      chk("fd_half", 9'h000, {8'h00, fd[p]});
      wr(CTRL12_OFS[p], 8'h60);
      idle(1);
      chk("spd_100", 9'h001, {8'h00, spd[p]});
      chk("fd_full", 9'h001, {8'h00, fd[p]});
      an_spd = 2'b11;
      an_fd = 2'b11;
      wr(CTRL12_OFS[p], 8'h80);
      rdc("ctrl12", CTRL12_OFS[p], 8'h80);
      chk("an_on", 9'h001, {8'h00, an_en[p]});
      chk("an_spd", 9'h001, {8'h00, spd[p]});
      chk("an_fd", 9'h001, {8'h00, fd[p]});
      an_fail[p] = 1'b1;
      idle(4);
      chk("fd_failed", 9'h000, {8'h00, fd[p]});
      an_fail[p] = 1'b0;
    end
    for (int i = 0; i < 5; i++)
    begin
      p = PRT[i];
      mode = MDS[i];
      delay = 9'(DLS[i]);
      wr(SPECIAL_OFS[p], 8'h10);
      rdr(SPECIAL_OFS[p]);
      chk("start_set", 9'h001, {8'h00, rd[SP_START]});
      k = 0;
      while (rd[SP_START] !== 1'b0 && k < 200)
      begin
        rdr(SPECIAL_OFS[p]);
        k++;
      end
      chk("start_clear", 9'h000, {8'h00, rd[SP_START]});
      chk("outcome", {7'h00, MDS[i]}, {7'h00, rd[6:5]});
      lo = DLS[i] * 5 / 2;
      chk("near_short", {8'h00, MDS[i] == OUT_SHORT && lo < NEAR_UNITS},
          {8'h00, rd[SP_NEAR_SHORT]});
      cnt[8] = rd[SP_CNT_MSB];
      rdr(RESULT_OFS[p]);
      cnt[7:0] = rd;
      if (MDS[i] != OUT_NORMAL)
      begin
        n_tests++;
        if ($isunknown(cnt) || cnt < lo || cnt > lo + 15)
        begin
          n_errors++;
          $display("BAD fault_count expected %0d seen %0d", lo, cnt);
        end
      end
    end
    // Second reset with the opposite strap levels
    {p1_s0, p1_s1, p2_an, p2_sp} = 4'h9;
    rst_n = 1'b0;
    idle(2);
    rst_n = 1'b1;
    idle(6);
    rdc("p1_ctrl12_rst", CTRL12_OFS[0], 8'hBF);
    rdc("p2_ctrl12_rst", CTRL12_OFS[1], 8'h7F);
    rdc("special_rst", SPECIAL_OFS[0], 8'h00);
    chk("an_enable_rst", 9'h001, {7'h00, an_en});
    conclude();
  end
endmodule
